/* dml_defs.svh */
/*
 Register indices, field positions, reset values and timing counts for the
 loop mode and configuration block.
 Assumes inclusion by its bare name; definitions only.
*/
`ifndef DML_DEFS_SVH
`define DML_DEFS_SVH

// Register indices; byte address is four times the index
`define DML_IDX_HW_CTRL 8'h01
`define DML_IDX_P_CTRL0 8'h1d
`define DML_IDX_P_MODE 8'h1f
`define DML_IDX_P_REF 8'h20
`define DML_IDX_P_RANGE 8'h29
`define DML_IDX_S_CTRL0 8'h2a
`define DML_IDX_S_MODE 8'h2c
`define DML_IDX_S_REF 8'h2d
`define DML_IDX_STATUS 8'h30

// Field positions
`define DML_HW_OVR_BIT 0
`define DML_HITLESS_SWITCH_ENABLE_BIT 0
`define DML_BW_LSB 1
`define DML_BW_MSB 3
`define DML_SLOPE_LSB 4
`define DML_SLOPE_MSB 5
`define DML_FINE_LSB 6
`define DML_FINE_MSB 7
`define DML_S_SLOPE_BIT 1

// Reset values
`define DML_RST_HW_CTRL 8'h00
`define DML_RST_P_CTRL0 8'h30
`define DML_RST_P_MODE 8'h03
`define DML_RST_P_REF 8'h00
`define DML_RST_P_RANGE 8'h00
`define DML_RST_S_CTRL0 8'h02
`define DML_RST_S_MODE 8'h02
`define DML_RST_S_REF 8'h00
`define DML_RST_STRAPS 2'h3

// Cycles the strap synchroniser needs before its value is trusted
`define DML_STRAP_SETTLE 2'h2

`endif

/* dml_pkg.sv */
/*
 Types for the loop mode and configuration block.
 Assumes dml_defs.svh for the numeric constants.
*/
package dml_pkg;

  localparam int DML_MAX_REFS = 16;

  typedef enum logic [1:0] {
    MODE_MAN_NORMAL = 2'h0,
    MODE_MAN_HOLD = 2'h1,
    MODE_MAN_FREE = 2'h2,
    MODE_AUTO = 2'h3
  } dml_mode_type;

  typedef enum logic [1:0] {
    OP_FREERUN,
    OP_NORMAL,
    OP_HOLDOVER
  } dml_op_type;

  typedef enum logic [3:0] {
    BW_0P1HZ, BW_1P7HZ, BW_3P5HZ, BW_7HZ_FAST, BW_14HZ, BW_56HZ,
    BW_890HZ, BW_0P3MHZ, BW_1P0MHZ, BW_3P0MHZ, BW_RESERVED
  } dml_bw_type;

  typedef enum logic [1:0] {
    RNG_12PPM, RNG_52PPM, RNG_83PPM, RNG_130PPM
  } dml_range_type;

  typedef enum logic [1:0] {
    SLP_885NS, SLP_7U5S, SLP_61US, SLP_FREE
  } dml_slope_type;

  typedef struct packed {
    dml_op_type op;
    logic [3:0] ref_sel;
    logic ever_locked;
    logic absorb;
    logic realign;
    dml_slope_type slope;
  } dml_loop_type;

  typedef struct packed {
    dml_bw_type bw;
    dml_range_type pull_in;
    dml_range_type hold_in;
  } dml_cfg_type;

  typedef struct packed {
    logic [1:0] strap_meta;
    logic [1:0] strap_sync;
    logic [DML_MAX_REFS-1:0] qual_meta;
    logic [DML_MAX_REFS-1:0] qual_sync;
    logic [1:0] fcls_meta;
    logic [1:0] fcls_sync;
    logic [1:0] settle;
    logic strap_done;
    logic [7:0] hw_ctrl;
    logic [7:0] p_ctrl0;
    logic [7:0] p_mode;
    logic [7:0] p_ref;
    logic [7:0] p_range;
    logic [7:0] s_ctrl0;
    logic [7:0] s_mode;
    logic [7:0] s_ref;
    logic ack;
    logic [31:0] rdata;
    dml_loop_type p_loop;
    dml_loop_type s_loop;
    dml_cfg_type p_cfg;
    dml_cfg_type s_cfg;
  } dml_state_type;

endpackage : dml_pkg

/* dml_mode_loop.sv */
/*
 Mode control and loop configuration for the primary and secondary loops,
 with an Avalon-MM register slave (one wait state per access).
 Assumes straps and reference monitor status arrive asynchronously and
 straps are pulled high on the board when left open.
*/
`include "dml_defs.svh"

// Behaviour
// - Straps sampled at reset set primary mode.
// - Open straps give automatic normal mode.
// - Strap mode loaded into readable mode register.
// - Override bit makes straps drive primary mode.
// - Manual normal: chosen reference, holdover on failure.
// - Manual holdover: stay in holdover.
// - Manual free-run: stay in free-run.
// - Automatic: best qualified reference, else fallback.
// - Secondary mode software only, reset free-run.
// - Primary bandwidth code decodes to bandwidth.
// - Wideband bandwidth follows reference frequency.
// - Code 111 uses the fine bandwidth selector.
// - Secondary bandwidth fixed, not programmable.
// - Pull-in code decodes to ppm range.
// - Hold-in range equals pull-in range.
// - Secondary pull-in/hold-in fixed 130 ppm.
// - Primary slope limit field, reset unrestricted.
// - Secondary slope bit: 61 us/s or unrestricted.
// - Hitless enabled absorbs phase on switch.
// - Hitless disabled realigns at slope limit.
// - Normal loop losing references enters holdover.
module dml_mode_loop #(
  parameter int NUM_REFS = 9
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Avalon-MM slave
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Pins and reference monitor
  input wire logic [1:0] i_startup_mode_straps,
  input wire logic [NUM_REFS-1:0] i_ref_qualified,
  input wire logic [1:0] i_ref_freq_class,
  // Loop controls
  output dml_pkg::dml_loop_type o_primary_loop,
  output dml_pkg::dml_loop_type o_secondary_loop,
  output dml_pkg::dml_cfg_type o_primary_cfg,
  output dml_pkg::dml_cfg_type o_secondary_cfg
);
  import dml_pkg::*;

  if (NUM_REFS < 1 || NUM_REFS > DML_MAX_REFS) begin : g_bad_refs
    $error("NUM_REFS must lie between 1 and 16");
  end

  dml_state_type s;
  dml_state_type next_s;
  logic [7:0] idx;
  logic req;
  logic do_wr;
  logic [1:0] p_eff_mode;
  logic [DML_MAX_REFS-1:0] qual_in;

  assign idx = i_avs_address[9:2];
  assign req = i_avs_read | i_avs_write;
  assign do_wr = i_avs_write & s.ack & i_avs_byteenable[0];
  assign o_avs_waitrequest = req & ~s.ack;
  assign o_avs_readdata = s.rdata;
  assign o_primary_loop = s.p_loop;
  assign o_secondary_loop = s.s_loop;
  assign o_primary_cfg = s.p_cfg;
  assign o_secondary_cfg = s.s_cfg;

  always_comb begin
    qual_in = '0;
    qual_in[NUM_REFS-1:0] = i_ref_qualified;
  end

  // Pin override selects strap pins over the software mode
  assign p_eff_mode = s.hw_ctrl[`DML_HW_OVR_BIT] ? s.strap_sync :
    s.p_mode[1:0];

  function automatic dml_range_type range_dec(input logic [1:0] code);
    case (code)
      2'h0: range_dec = RNG_12PPM;
      2'h1: range_dec = RNG_52PPM;
      2'h2: range_dec = RNG_130PPM;
      default: range_dec = RNG_83PPM;
    endcase
  endfunction : range_dec

  function automatic dml_bw_type bw_dec(input logic [2:0] code,
      input logic [1:0] fine, input logic [1:0] fcls);
    case (code)
      3'h0: bw_dec = BW_0P1HZ;
      3'h1: bw_dec = BW_1P7HZ;
      3'h2: bw_dec = BW_3P5HZ;
      3'h5: begin
        // Wideband depends on reference rate
        case (fcls)
          2'h0: bw_dec = BW_14HZ;
          2'h1: bw_dec = BW_56HZ;
          default: bw_dec = BW_890HZ;
        endcase
      end
      3'h6: bw_dec = BW_7HZ_FAST;
      3'h7: begin
        case (fine)
          2'h0: bw_dec = BW_0P3MHZ;
          2'h1: bw_dec = BW_1P0MHZ;
          2'h2: bw_dec = BW_3P0MHZ;
          default: bw_dec = BW_RESERVED;
        endcase
      end
      default: bw_dec = BW_RESERVED;
    endcase
  endfunction : bw_dec

  // One step of a loop's mode machine
  function automatic dml_loop_type loop_step(input dml_loop_type cur,
      input logic [1:0] mode, input logic [3:0] man_ref,
      input logic [DML_MAX_REFS-1:0] qual, input logic hitless_switch_enable,
      input dml_slope_type slope);
    dml_loop_type nx;
    logic found;
    logic [3:0] best;
    nx = cur;
    nx.absorb = 1'b0;
    nx.realign = 1'b0;
    nx.slope = slope;
    found = 1'b0;
    best = 4'h0;
    // Lowest index is highest priority
    for (int i = DML_MAX_REFS - 1; i >= 0; i--) begin
      if (qual[i]) begin
        found = 1'b1;
        best = 4'(i);
      end
    end
    case (mode)
      MODE_MAN_NORMAL: begin
        if (qual[man_ref]) begin
          nx.op = OP_NORMAL;
          nx.ref_sel = man_ref;
        end else begin
          nx.op = cur.ever_locked ? OP_HOLDOVER : OP_FREERUN;
        end
      end
      MODE_MAN_HOLD: nx.op = OP_HOLDOVER;
      MODE_MAN_FREE: nx.op = OP_FREERUN;
      MODE_AUTO: begin
        if (found) begin
          nx.op = OP_NORMAL;
          nx.ref_sel = best;
        end else begin
          nx.op = cur.ever_locked ? OP_HOLDOVER : OP_FREERUN;
        end
      end
      default: nx.op = OP_FREERUN;
    endcase
    if (nx.op == OP_NORMAL) begin
      nx.ever_locked = 1'b1;
    end
    if (cur.op == OP_NORMAL && nx.op == OP_NORMAL &&
        nx.ref_sel != cur.ref_sel) begin
      nx.absorb = hitless_switch_enable;
      nx.realign = ~hitless_switch_enable;
    end
    loop_step = nx;
  endfunction : loop_step

  always_comb begin
    next_s = s;
    // Two-stage synchronisers
    next_s.strap_meta = i_startup_mode_straps;
    next_s.strap_sync = s.strap_meta;
    next_s.qual_meta = qual_in;
    next_s.qual_sync = s.qual_meta;
    next_s.fcls_meta = i_ref_freq_class;
    next_s.fcls_sync = s.fcls_meta;

    // Load settled straps once after reset release
    if (!s.strap_done) begin
      if (s.settle == `DML_STRAP_SETTLE) begin
        next_s.p_mode = {6'h00, s.strap_sync};
        next_s.strap_done = 1'b1;
      end else begin
        next_s.settle = s.settle + 2'h1;
      end
    end

    // Bus: one wait state, read data captured in the wait cycle
    next_s.ack = req & ~s.ack;
    if (req && !s.ack) begin
      next_s.rdata = 32'h0;
      case (idx)
        `DML_IDX_HW_CTRL: next_s.rdata[7:0] = s.hw_ctrl;
        `DML_IDX_P_CTRL0: next_s.rdata[7:0] = s.p_ctrl0;
        `DML_IDX_P_MODE: next_s.rdata[7:0] = s.p_mode;
        `DML_IDX_P_REF: next_s.rdata[7:0] = s.p_ref;
        `DML_IDX_P_RANGE: next_s.rdata[7:0] = s.p_range;
        `DML_IDX_S_CTRL0: next_s.rdata[7:0] = s.s_ctrl0;
        `DML_IDX_S_MODE: next_s.rdata[7:0] = s.s_mode;
        `DML_IDX_S_REF: next_s.rdata[7:0] = s.s_ref;
        `DML_IDX_STATUS: next_s.rdata[15:0] = {s.s_loop.ref_sel,
          s.p_loop.ref_sel, 2'h0, s.strap_sync, s.s_loop.op, s.p_loop.op};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (do_wr) begin
      case (idx)
        `DML_IDX_HW_CTRL: next_s.hw_ctrl = {7'h00,
          i_avs_writedata[`DML_HW_OVR_BIT]};
        `DML_IDX_P_CTRL0: next_s.p_ctrl0 = i_avs_writedata[7:0];
        `DML_IDX_P_MODE: begin
          if (s.strap_done) begin
            next_s.p_mode = {6'h00, i_avs_writedata[1:0]};
          end
        end
        `DML_IDX_P_REF: next_s.p_ref = {4'h0, i_avs_writedata[3:0]};
        `DML_IDX_P_RANGE: next_s.p_range = {6'h00, i_avs_writedata[1:0]};
        `DML_IDX_S_CTRL0: next_s.s_ctrl0 = {6'h00, i_avs_writedata[1:0]};
        `DML_IDX_S_MODE: next_s.s_mode = {6'h00,
          i_avs_writedata[1:0]};
        `DML_IDX_S_REF: next_s.s_ref = {4'h0, i_avs_writedata[3:0]};
        default: next_s.s_ref = s.s_ref;
      endcase
    end

    // Loop mode machines
    next_s.p_loop = loop_step(s.p_loop, p_eff_mode, s.p_ref[3:0],
      s.qual_sync, s.p_ctrl0[`DML_HITLESS_SWITCH_ENABLE_BIT],
      dml_slope_type'(s.p_ctrl0[`DML_SLOPE_MSB:`DML_SLOPE_LSB]));
    next_s.s_loop = loop_step(s.s_loop, s.s_mode[1:0], s.s_ref[3:0],
      s.qual_sync, s.s_ctrl0[`DML_HITLESS_SWITCH_ENABLE_BIT],
      s.s_ctrl0[`DML_S_SLOPE_BIT] ? SLP_FREE : SLP_61US);

    // Configuration decode
    next_s.p_cfg.bw = bw_dec(s.p_ctrl0[`DML_BW_MSB:`DML_BW_LSB],
      s.p_ctrl0[`DML_FINE_MSB:`DML_FINE_LSB], s.fcls_sync);
    next_s.p_cfg.pull_in = range_dec(s.p_range[1:0]);
    next_s.p_cfg.hold_in = next_s.p_cfg.pull_in;
    next_s.s_cfg.bw = BW_14HZ;
    next_s.s_cfg.pull_in = RNG_130PPM;
    next_s.s_cfg.hold_in = RNG_130PPM;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
      s.strap_meta <= `DML_RST_STRAPS;
      s.strap_sync <= `DML_RST_STRAPS;
      s.hw_ctrl <= `DML_RST_HW_CTRL;
      s.p_ctrl0 <= `DML_RST_P_CTRL0;
      s.p_mode <= `DML_RST_P_MODE;
      s.p_ref <= `DML_RST_P_REF;
      s.p_range <= `DML_RST_P_RANGE;
      s.s_ctrl0 <= `DML_RST_S_CTRL0;
      s.s_mode <= `DML_RST_S_MODE;
      s.s_ref <= `DML_RST_S_REF;
      s.p_loop.slope <= SLP_FREE;
      s.s_loop.slope <= SLP_FREE;
      s.s_cfg.bw <= BW_14HZ;
      s.s_cfg.pull_in <= RNG_130PPM;
      s.s_cfg.hold_in <= RNG_130PPM;
    end else begin
      s <= next_s;
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence p_normal_s;
    s.p_loop.op == OP_NORMAL;
  endsequence
  sequence p_switch_s;
    p_normal_s ##1 (p_normal_s and
      (s.p_loop.ref_sel != $past(s.p_loop.ref_sel)));
  endsequence

  strap_settle_a: assert property (
    (!s.strap_done && i_rstn) |-> ##[1:3] s.strap_done)
    else $error("straps not loaded after reset");
  open_strap_a: assert property (
    !s.strap_done |-> s.p_mode == 8'h03)
    else $error("primary mode not automatic before strap load");
  strap_load_a: assert property (
    $rose(s.strap_done) |-> s.p_mode[1:0] == $past(s.strap_sync))
    else $error("strap level not loaded into mode register");
  pin_override_a: assert property (
    (s.hw_ctrl[0] && s.strap_sync == 2'h2) |=> s.p_loop.op == OP_FREERUN)
    else $error("override did not follow strap pins");
  man_normal_a: assert property (
    (p_eff_mode == 2'h0 && s.qual_sync[s.p_ref[3:0]]) |=>
      (s.p_loop.op == OP_NORMAL && s.p_loop.ref_sel == $past(s.p_ref[3:0])))
    else $error("manual normal did not lock chosen reference");
  man_hold_a: assert property (
    p_eff_mode == 2'h1 |=> s.p_loop.op == OP_HOLDOVER)
    else $error("manual holdover not held");
  man_free_a: assert property (
    p_eff_mode == 2'h2 |=> s.p_loop.op == OP_FREERUN)
    else $error("manual free-run not held");
  auto_pick_a: assert property (
    (p_eff_mode == 2'h3 && s.qual_sync[1:0] == 2'h2) |=>
      (s.p_loop.op == OP_NORMAL && s.p_loop.ref_sel == 4'h1))
    else $error("automatic mode missed best qualified reference");
  auto_fallback_a: assert property (
    (p_eff_mode == 2'h3 && s.qual_sync == '0 && s.p_loop.ever_locked) |=>
      s.p_loop.op == OP_HOLDOVER)
    else $error("no holdover after losing all references");
  sec_mode_a: assert property (
    !(do_wr && idx == `DML_IDX_S_MODE) |=> $stable(s.s_mode))
    else $error("secondary mode changed without a write");
  hitless_a: assert property (
    p_switch_s |-> (s.p_loop.absorb == $past(s.p_ctrl0[0]) &&
      s.p_loop.realign == !$past(s.p_ctrl0[0])))
    else $error("switch pulse disagrees with hitless enable");
  fine_bw_a: assert property (
    s.p_cfg.bw == BW_1P0MHZ |-> $past(s.p_ctrl0[7:6]) == 2'h1 &&
      $past(s.p_ctrl0[3:1]) == 3'h7)
    else $error("fine bandwidth decode wrong");

  // Configuration decode checks and the bus wait-state check
  wideband_a: assert property (
    (s.p_ctrl0[3:1] == 3'h5 && s.fcls_sync == 2'h1) |=> s.p_cfg.bw == BW_56HZ)
    else $error("wideband bandwidth ignores reference rate");
  range_a: assert property (
    s.p_range[1:0] == 2'h2 |=> s.p_cfg.pull_in == RNG_130PPM)
    else $error("pull-in range decode wrong");
  sec_slope_a: assert property (
    !s.s_ctrl0[`DML_S_SLOPE_BIT] |=> s.s_loop.slope == SLP_61US)
    else $error("secondary slope limit not applied");
  bus_wait_a: assert property (
    (req && !s.ack) |=> (!req || !o_avs_waitrequest))
    else $error("waitrequest held more than one cycle");

endmodule : dml_mode_loop

/* dml_mode_loop_test.sv */
/*
 Self-checking bench for the loop mode and configuration block.
 Assumes dml_pkg and dml_defs.svh; the bench drives every port itself.
*/
`include "dml_defs.svh"
module dml_mode_loop_test import dml_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] RI [9] = '{`DML_IDX_HW_CTRL, `DML_IDX_P_CTRL0,
    `DML_IDX_P_MODE, `DML_IDX_P_REF, `DML_IDX_P_RANGE, `DML_IDX_S_CTRL0,
    `DML_IDX_S_MODE, `DML_IDX_S_REF, 8'h05};
  localparam logic [7:0] RV [9] = '{`DML_RST_HW_CTRL, `DML_RST_P_CTRL0,
    `DML_RST_P_MODE, `DML_RST_P_REF, `DML_RST_P_RANGE, `DML_RST_S_CTRL0,
    `DML_RST_S_MODE, `DML_RST_S_REF, 8'h00};

  logic clk, rstn, rd, wr, wreq, saw_abs, saw_rel;
  logic [9:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, q;
  logic [1:0] straps, fcls;
  logic [8:0] qual;
  dml_loop_type p_loop, s_loop;
  dml_cfg_type p_cfg, s_cfg;
  int n_errors, samples_checked, cycles;

  dml_mode_loop #(.NUM_REFS(9)) i_dut (
    .i_core_clk(clk), .i_rstn(rstn), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_startup_mode_straps(straps),
    .i_ref_qualified(qual), .i_ref_freq_class(fcls),
    .o_primary_loop(p_loop), .o_secondary_loop(s_loop),
    .o_primary_cfg(p_cfg), .o_secondary_cfg(s_cfg));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Pulse catcher and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (p_loop.absorb === 1'b1) saw_abs <= 1'b1;
    if (p_loop.realign === 1'b1) saw_rel <= 1'b1;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task stop_test;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task chk_fld(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_fld

  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  // One Avalon access; held until waitrequest is seen low
  task bus_xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                input logic [3:0] b);
    @(posedge clk);
    addr <= {idx, 2'h0};
    rd <= ~w;
    wr <= w;
    wdata <= {24'h0, d};
    be <= b;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus_xfer

  task wr_reg(input logic [7:0] idx, input logic [7:0] d);
    bus_xfer(1'b1, idx, d, 4'hf);
    wait_cyc(3);
  endtask : wr_reg

  task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus_xfer(1'b0, idx, 8'h00, 4'hf);
    chk_reg(q, {24'h0, exp});
  endtask : rd_chk

  task set_qual(input logic [8:0] v);
    @(posedge clk);
    saw_abs <= 1'b0;
    saw_rel <= 1'b0;
    qual <= v;
    wait_cyc(5);
  endtask : set_qual

  task do_reset(input logic [1:0] s);
    @(posedge clk);
    rstn <= 1'b0;
    straps <= s;
    qual <= '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wait_cyc(5);
  endtask : do_reset

  function automatic dml_bw_type bw_exp(input logic [2:0] c,
                                        input logic [1:0] v);
    case (c)
      3'h0: return BW_0P1HZ;
      3'h1: return BW_1P7HZ;
      3'h2: return BW_3P5HZ;
      3'h5: return v == 2'h0 ? BW_14HZ : v == 2'h1 ? BW_56HZ : BW_890HZ;
      3'h6: return BW_7HZ_FAST;
      3'h7: return v == 2'h0 ? BW_0P3MHZ : v == 2'h1 ? BW_1P0MHZ :
                   v == 2'h2 ? BW_3P0MHZ : BW_RESERVED;
      default: return BW_RESERVED;
    endcase
  endfunction : bw_exp

  task t_straps;
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      rd_chk(`DML_IDX_P_MODE, 8'(s));
      chk_fld(8'(p_loop.op), 8'(s == 1 ? OP_HOLDOVER : OP_FREERUN));
    end
    rd_chk(`DML_IDX_P_MODE, 8'h03);
  endtask : t_straps

  task t_reset_vals;
    for (int i = 0; i < 9; i++) begin
      rd_chk(RI[i], RV[i]);
    end
    chk_fld(8'(s_loop.op), 8'(OP_FREERUN));
    chk_fld(8'(p_loop.slope), 8'(SLP_FREE));
    chk_fld(8'(s_loop.slope), 8'(SLP_FREE));
    chk_fld(8'(s_cfg), 8'({BW_14HZ, RNG_130PPM, RNG_130PPM}));
    // Unmapped and disabled-lane writes must leave nothing behind
    wr_reg(8'h05, 8'h5a);
    rd_chk(8'h05, 8'h00);
    bus_xfer(1'b1, `DML_IDX_HW_CTRL, 8'h01, 4'h0);
    rd_chk(`DML_IDX_HW_CTRL, 8'h00);
  endtask : t_reset_vals

  task t_bw;
    for (int c = 0; c < 8; c++) begin
      for (int v = 0; v < 4; v++) begin
        @(posedge clk);
        fcls <= 2'(v);
        wr_reg(`DML_IDX_P_CTRL0, {2'(v), 2'h3, 3'(c), 1'b0});
        wait_cyc(2);
        chk_fld(8'(p_cfg.bw), 8'(bw_exp(3'(c), 2'(v))));
      end
    end
    chk_fld(8'(s_cfg.bw), 8'(BW_14HZ));
  endtask : t_bw

  task t_range_slope;
    dml_range_type rx [4];
    rx = '{RNG_12PPM, RNG_52PPM, RNG_130PPM, RNG_83PPM};
    for (int r = 0; r < 4; r++) begin
      wr_reg(`DML_IDX_P_RANGE, 8'(r));
      chk_fld(8'(p_cfg.pull_in), 8'(rx[r]));
      chk_fld(8'(p_cfg.hold_in), 8'(rx[r]));
      wr_reg(`DML_IDX_P_CTRL0, {2'h0, 2'(r), 4'h0});
      chk_fld(8'(p_loop.slope), 8'(r));
    end
    wr_reg(`DML_IDX_S_CTRL0, 8'h00);
    chk_fld(8'(s_loop.slope), 8'(SLP_61US));
    wr_reg(`DML_IDX_S_CTRL0, 8'h02);
    chk_fld(8'(s_loop.slope), 8'(SLP_FREE));
    chk_fld(8'(s_cfg.pull_in), 8'(RNG_130PPM));
  endtask : t_range_slope

  task t_modes;
    wr_reg(`DML_IDX_P_MODE, 8'h02);
    set_qual(9'h001);
    chk_fld(8'(p_loop.op), 8'(OP_FREERUN));
    wr_reg(`DML_IDX_P_MODE, 8'h01);
    chk_fld(8'(p_loop.op), 8'(OP_HOLDOVER));
    wr_reg(`DML_IDX_P_REF, 8'h03);
    wr_reg(`DML_IDX_P_MODE, 8'h00);
    set_qual(9'h009);
    chk_fld(8'(p_loop.op), 8'(OP_NORMAL));
    chk_fld(8'(p_loop.ref_sel), 8'h03);
    set_qual(9'h001);
    chk_fld(8'(p_loop.op), 8'(OP_HOLDOVER));
    wr_reg(`DML_IDX_P_MODE, 8'h03);
    set_qual(9'h006);
    chk_fld(8'(p_loop.ref_sel), 8'h01);
    wr_reg(`DML_IDX_P_CTRL0, 8'h31);
    set_qual(9'h004);
    chk_fld(8'(p_loop.ref_sel), 8'h02);
    chk_fld(8'({saw_abs, saw_rel}), 8'h02);
    wr_reg(`DML_IDX_P_CTRL0, 8'h30);
    set_qual(9'h006);
    chk_fld(8'({saw_abs, saw_rel}), 8'h01);
    set_qual(9'h000);
    chk_fld(8'(p_loop.op), 8'(OP_HOLDOVER));
    // Straps take over the primary mode while the override is set
    wr_reg(`DML_IDX_P_MODE, 8'h02);
    @(posedge clk);
    straps <= 2'h1;
    wr_reg(`DML_IDX_HW_CTRL, 8'h01);
    chk_fld(8'(p_loop.op), 8'(OP_HOLDOVER));
    rd_chk(`DML_IDX_P_MODE, 8'h02);
    // Software asks holdover while the straps ask free-run
    wr_reg(`DML_IDX_P_MODE, 8'h01);
    @(posedge clk);
    straps <= 2'h2;
    wait_cyc(4);
    chk_fld(8'(p_loop.op), 8'(OP_FREERUN));
    wr_reg(`DML_IDX_HW_CTRL, 8'h00);
    chk_fld(8'(p_loop.op), 8'(OP_HOLDOVER));
    set_qual(9'h001);
    wr_reg(`DML_IDX_S_MODE, 8'h03);
    chk_fld(8'(s_loop.op), 8'(OP_NORMAL));
    bus_xfer(1'b0, `DML_IDX_STATUS, 8'h00, 4'hf);
    chk_reg(q, {20'h0, 4'h1, 4'h2, 2'(OP_NORMAL), 2'(OP_HOLDOVER)});
  endtask : t_modes

  initial begin
    rstn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = '0;
    be = 4'hf;
    wdata = '0;
    straps = 2'h3;
    qual = '0;
    fcls = 2'h0;
    saw_abs = 1'b0;
    saw_rel = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    t_straps();
    t_reset_vals();
    t_bw();
    t_range_slope();
    t_modes();
    stop_test();
  end
endmodule : dml_mode_loop_test
